// file: shared/cpsm_consts.vh
// Constants for the configuration port status monitor.
// Included by the design files by bare name; holds definitions only.
`ifndef CPSM_CONSTS_VH
`define CPSM_CONSTS_VH

`define CPSM_STATUS_W      32
`define CPSM_ERRN_BIT      7
`define CPSM_SYNC_BIT      6
`define CPSM_READBACK_BIT  5
`define CPSM_ABORTN_BIT    4
`define CPSM_RSVD_OLD      4'hF
`define CPSM_RSVD_NEW      4'hB
`define CPSM_UPPER_ZERO    24'h000000
`define CPSM_FLAGS_IDLE    4'h9
`define CPSM_ECHO_PAD      28'h0000000
`define CPSM_ADDR_W        4
`define CPSM_ADDR_CTRL     4'h0
`define CPSM_ADDR_STATUS   4'h4
`define CPSM_ADDR_ECHO     4'h8
`define CPSM_CTRL_NEWGEN   0
`define CPSM_ECHO_DONE     0
`define CPSM_ECHO_ERRN     1
`define CPSM_ECHO_INITN    2
`define CPSM_ECHO_PARTIAL_DONE_ECHO   3

`endif

// file: src/cpsm_event_pulse.v
// Rising-edge detector turning a command level into a one-cycle event.
// Assumes the input is synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cpsm_event_pulse
(
	input  wire sys_clk,
	input  wire reset,
	input  wire level,
	output wire pulse
);
	reg levelDly_ff;

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			levelDly_ff <= 1'b0;
		else
			levelDly_ff <= level;
	end

	assign pulse = level & ~levelDly_ff;
endmodule
`default_nettype wire

// file: src/cpsm_status_encode.v
// Packs the four status flags and the reserved nibble into the status word.
// Assumes the flags are settled before the clock edge; output is combinational.
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_consts.vh"
module cpsm_status_encode
(
	input  wire                       errFlag,
	input  wire                       syncFlag,
	input  wire                       readbackFlag,
	input  wire                       abortFlag,
	input  wire                       newGen,
	output wire [`CPSM_STATUS_W-1:0]  statusWord
);
	wire [3:0] rsvd;

	assign rsvd = newGen ? `CPSM_RSVD_NEW : `CPSM_RSVD_OLD;
	// Active-low error and abort, active-high sync and readback.
	assign statusWord = {`CPSM_UPPER_ZERO, ~errFlag, syncFlag, readbackFlag, ~abortFlag, rsvd};
endmodule
`default_nettype wire

// file: src/cpsm_status_monitor.v
// Status side of the internal configuration access port.
// Assumes all command inputs are synchronous to sys_clk and are levels or pulses.
// What this block and its controller are required to do
// RULE1 - Status output is 32 bits; only the low byte carries meaning.
// RULE2 - Bit 7 is active-low configuration error flag.
// RULE3 - Bit 6 is high once the sync word was received.
// RULE4 - Bit 5 is high while readback is in progress.
// RULE5 - Bit 4 is low while an abort is in progress.
// RULE6 - Bits 3:0 read F on older generation, B on newer.
// RULE7 - Upper nibble: 9 idle, D sync, 5 sync with error, 1 error.
// RULE8 - After full configuration 0x9F; sync word moves it to 0xDF.
// RULE9 - CRC error shows 0x5F for one cycle then 0x1F; here 0x5F holds while syncWordSeen stays high.
// RULE10 - Error echo goes low on full or per-frame CRC error.
// RULE11 - CRC reset command clears error and releases init pin pull.
// RULE12 - Sync after error moves status from 0x1F to 0x5F.
// RULE13 - CRC reset while synced with error moves 0x5F to 0xDF.
// RULE14 - Release sync command without error returns 0xDF to 0x9F.
// RULE15 - Done output goes high when full configuration completes.
// RULE16 - Controller uses done echo only on monolithic or same-slice setups.
// RULE17 - For far slices controller uses startup sequence end, not echoes.
// RULE18 - Controller may use status byte to detect errors and reload.
// RULE19 - CRC error is readable back as a flag through the port.
// RULE20 - Controller must not pull init or program pins before partial loads.
// RULE21 - Controller decodes only status bits 7 to 4.
// RULE22 - Status updates on the port clock; each code lasts a cycle.
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "cpsm_consts.vh"
module cpsm_status_monitor
(
	input  wire                       sys_clk,
	input  wire                       reset,
	input  wire                       fullConfigDone,
	input  wire                       syncWordSeen,
	input  wire                       crcErrorFull,
	input  wire                       crcErrorFrame,
	input  wire                       crcResetCommand,
	input  wire                       releaseSyncCommand,
	input  wire                       readbackActive,
	input  wire                       abortActive,
	input  wire                       partialFrameDone,
	input  wire [`CPSM_ADDR_W-1:0]    regAddr,
	input  wire [`CPSM_STATUS_W-1:0]  regWrData,
	input  wire                       regWrite,
	input  wire                       regRead,
	output reg  [`CPSM_STATUS_W-1:0]  regRdData,
	output reg  [`CPSM_STATUS_W-1:0]  statusOut,
	output reg                        donePad_ff,
	output reg                        initPadN_ff,
	output reg                        partialDoneEcho,
	output reg                        partialErrorEchoN
);
	localparam ST_UNSYNC  = 2'b00;
	localparam ST_SYNC    = 2'b01;
	localparam ST_ERRSYNC = 2'b10;
	localparam ST_ERROR   = 2'b11;

	reg  [1:0] state_ff;
	reg  [1:0] nxt_state;
	reg        newGen_ff;
	reg        nxt_newGen;
	reg        nxt_donePad;
	reg        nxt_initPadN;
	reg        nxt_errorEchoN;
	reg        nxt_doneEcho;
	reg  [`CPSM_STATUS_W-1:0] nxt_rdData;
	wire       crcErr;
	wire       syncPulse;
	wire       crcRstPulse;
	wire       desyncPulse;
	wire       donePulse;
	reg        errFlag;
	reg        syncFlag;
	wire [`CPSM_STATUS_W-1:0] statusWord;

	assign crcErr = crcErrorFull | crcErrorFrame;  // [RULE10]

	// Commands are edge-detected so that a level held high counts only once.
	cpsm_event_pulse u_syncEdge
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (syncWordSeen),
		.pulse   (syncPulse)
	);

	cpsm_event_pulse u_crcRstEdge
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (crcResetCommand),
		.pulse   (crcRstPulse)
	);

	cpsm_event_pulse u_desyncEdge
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (releaseSyncCommand),
		.pulse   (desyncPulse)
	);

	// Done latches on the completion edge and stays high until reset.
	cpsm_event_pulse u_doneEdge
	(
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (fullConfigDone),
		.pulse   (donePulse)
	);

	// A CRC error always wins over commands arriving in the same cycle.
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_UNSYNC:
			begin
				if (crcErr)
					nxt_state = ST_ERROR;
				else if (syncPulse)
					nxt_state = ST_SYNC;  // [RULE8]
			end
			ST_SYNC:
			begin
				if (crcErr)
					nxt_state = ST_ERRSYNC;  // [RULE9]
				else if (desyncPulse)
					nxt_state = ST_UNSYNC;  // [RULE14]
			end
			ST_ERRSYNC:
			begin
				// Only a sync word still present keeps this code, so a fresh error shows it once.
				if (crcRstPulse && !crcErr)
					nxt_state = ST_SYNC;  // [RULE13]
				else if (desyncPulse || !syncWordSeen)
					nxt_state = ST_ERROR;  // [RULE9]
			end
			ST_ERROR:
			begin
				if (syncPulse && !crcErr)
					nxt_state = ST_ERRSYNC;  // [RULE12]
				else if (crcRstPulse && !crcErr)
					nxt_state = ST_UNSYNC;  // [RULE11]
			end
			default:
				nxt_state = ST_UNSYNC;
		endcase
	end

	// Error and sync flags of each state, as the upper status nibble shows them.
	always @*
	begin
		errFlag  = 1'b0;
		syncFlag = 1'b0;
		case (nxt_state)
			ST_UNSYNC:
			begin
				errFlag  = 1'b0;
				syncFlag = 1'b0;
			end
			ST_SYNC:
			begin
				errFlag  = 1'b0;
				syncFlag = 1'b1;  // [RULE3]
			end
			ST_ERRSYNC:
			begin
				errFlag  = 1'b1;  // [RULE2] [RULE19]
				syncFlag = 1'b1;
			end
			ST_ERROR:
			begin
				errFlag  = 1'b1;
				syncFlag = 1'b0;
			end
			default:
			begin
				errFlag  = 1'b0;
				syncFlag = 1'b0;
			end
		endcase
	end

	// The generation select takes effect at the same edge as the control write.
	always @*
	begin
		nxt_newGen = newGen_ff;
		if (regWrite && (regAddr == `CPSM_ADDR_CTRL))
			nxt_newGen = regWrData[`CPSM_CTRL_NEWGEN];  // [RULE6]
	end

	cpsm_status_encode u_encode
	(
		.errFlag      (errFlag),
		.syncFlag     (syncFlag),
		.readbackFlag (readbackActive),  // [RULE4]
		.abortFlag    (abortActive),  // [RULE5]
		.newGen       (nxt_newGen),
		.statusWord   (statusWord)
	);

	// Init pin and error echo next values follow the next state, in step with the status word.
	always @*
	begin
		nxt_donePad    = donePad_ff | donePulse;  // [RULE15]
		nxt_initPadN   = ~nxt_state[1];  // [RULE10] [RULE11]
		nxt_errorEchoN = ~nxt_state[1];  // [RULE10]
		nxt_doneEcho   = partialFrameDone;
	end

	// Read data next value; unmapped addresses and idle cycles read as zero.
	always @*
	begin
		nxt_rdData = {`CPSM_STATUS_W{1'b0}};
		if (regRead)
		begin
			case (regAddr)
				`CPSM_ADDR_CTRL:
					nxt_rdData = {{(`CPSM_STATUS_W-1){1'b0}}, newGen_ff};
				`CPSM_ADDR_STATUS:
					nxt_rdData = statusOut;  // [RULE19]
				`CPSM_ADDR_ECHO:
					nxt_rdData = {`CPSM_ECHO_PAD, partialDoneEcho, initPadN_ff, partialErrorEchoN, donePad_ff};
				default:
					nxt_rdData = {`CPSM_STATUS_W{1'b0}};
			endcase
		end
	end

	// One register per output, so that every port comes straight from a flip-flop.
	// State register; the status word is encoded from its next value.
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			state_ff <= ST_UNSYNC;
		else
			state_ff <= nxt_state;  // [RULE22]
	end

	// The generation select survives until the next control write.
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			newGen_ff <= 1'b0;
		else
			newGen_ff <= nxt_newGen;
	end

	// Reset shows the idle code with the older reserved nibble.
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			statusOut <= {`CPSM_UPPER_ZERO, `CPSM_FLAGS_IDLE, `CPSM_RSVD_OLD};
		else
			statusOut <= statusWord;  // [RULE1] [RULE7]
	end

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			donePad_ff <= 1'b0;
		else
			donePad_ff <= nxt_donePad;
	end

	// The init pin and the error echo are released together by the CRC reset command.
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			initPadN_ff <= 1'b1;
		else
			initPadN_ff <= nxt_initPadN;
	end

	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			partialErrorEchoN <= 1'b1;
		else
			partialErrorEchoN <= nxt_errorEchoN;
	end

	// The completion echo repeats the frame-done level one cycle later.
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			partialDoneEcho <= 1'b0;
		else
			partialDoneEcho <= nxt_doneEcho;
	end

	// Read data stands only in the cycle after the read strobe.
	always @(posedge sys_clk or posedge reset)
	begin
		if (reset)
			regRdData <= {`CPSM_STATUS_W{1'b0}};
		else
			regRdData <= nxt_rdData;
	end
endmodule
`default_nettype wire

// file: tb/cpsm_ctrl_model.sv
// Reconfiguration controller model that watches the status word.
// Assumes the status word is synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cpsm_ctrl_model
(
	input wire logic		sys_clk,
	input wire logic		reset,
	input wire logic [31:0]	statusWord,
	output logic			sawError_ff
);
	// Only status bit 7, the error flag, is decoded; the rest is ignored.
	// Errors are latched for a later reload; no pin or done echo is used.
	always_ff @(posedge sys_clk or posedge reset)
		if (reset)
			sawError_ff <= 1'b0;
		else if (!statusWord[7])
			sawError_ff <= 1'b1;
endmodule
`default_nettype wire

// file: tb/cpsm_status_chk.sv
// Assertions on the status word and the error echoes of the status monitor.
// Bound to cpsm_status_monitor and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cpsm_status_chk
(
	input wire logic		sys_clk,
	input wire logic		reset,
	input wire logic		syncWordSeen,
	input wire logic		crcErrorFull,
	input wire logic		crcErrorFrame,
	input wire logic		crcResetCommand,
	input wire logic		releaseSyncCommand,
	input wire logic		readbackActive,
	input wire logic		abortActive,
	input wire logic [31:0]	statusOut,
	input wire logic		initPadN_ff,
	input wire logic		partialErrorEchoN
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire logic crcErr = crcErrorFull | crcErrorFrame;
	chk_upper_zero: assert property (statusOut[31:8] == 24'h000000) else $error("upper bits set");
	chk_low_nibble: assert property (statusOut[3:0] inside {4'hF, 4'hB}) else $error("bad low nibble");
	chk_sync_entry: assert property ($rose(syncWordSeen) && statusOut[7:4] == 4'h9 && !crcErr |=>
		statusOut[7:4] == 4'hD) else $error("sync word did not set sync");
	chk_crc_error: assert property (crcErr && statusOut[7:4] == 4'hD |=>
		statusOut[7:4] == 4'h5) else $error("crc error not shown");
	chk_echo_low: assert property (crcErr |=> !initPadN_ff && !partialErrorEchoN) else $error("echo high");
	chk_crc_reset: assert property ($rose(crcResetCommand) && statusOut[7:4] == 4'h5 && !crcErr |=>
		statusOut[7:4] == 4'hD && initPadN_ff && partialErrorEchoN) else $error("crc reset failed");
	chk_sync_release: assert property ($rose(releaseSyncCommand) && statusOut[7:4] == 4'hD && !crcErr |=>
		statusOut[7:4] == 4'h9) else $error("release did not return to idle");
	chk_resync_error: assert property ($rose(syncWordSeen) && statusOut[7:4] == 4'h1 && !crcErr |=>
		statusOut[7:4] == 4'h5) else $error("resync after error wrong");
	chk_readback_bit: assert property (readbackActive |=> statusOut[5]) else $error("readback bit low");
	chk_abort_bit: assert property (abortActive && statusOut[7] && !crcErr |=>
		!statusOut[4] && statusOut[7]) else $error("abort bit high");
endmodule
bind cpsm_status_monitor cpsm_status_chk i_chk (.sys_clk(sys_clk), .reset(reset), .syncWordSeen(syncWordSeen),
	.crcErrorFull(crcErrorFull), .crcErrorFrame(crcErrorFrame), .crcResetCommand(crcResetCommand),
	.releaseSyncCommand(releaseSyncCommand), .readbackActive(readbackActive), .abortActive(abortActive),
	.statusOut(statusOut), .initPadN_ff(initPadN_ff), .partialErrorEchoN(partialErrorEchoN));
`default_nettype wire

// file: tb/tb_config_port_status_monitor.sv
// Testbench for the status monitor: command sequences and register reads.
// Command inputs travel in one vector driven on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb_config_port_status_monitor;
	logic			sys_clk = 1'b0;
	logic			reset = 1'b1;
	logic [8:0]		cmd = 9'h000;
	logic [3:0]		regAddr = 4'h0;
	logic [31:0]	regWrData = 32'h00000000;
	logic			regWrite = 1'b0;
	logic			regRead = 1'b0;
	wire [31:0]		regRdData, statusOut;
	wire			donePad_ff, initPadN_ff, partialDoneEcho, partialErrorEchoN, sawError_ff;
	int				fails = 0;
	int				samples_checked = 0;
	always #12.5 sys_clk = ~sys_clk;
	cpsm_status_monitor i_dut (.sys_clk(sys_clk), .reset(reset), .fullConfigDone(cmd[0]), .syncWordSeen(cmd[1]),
		.crcErrorFull(cmd[2]), .crcErrorFrame(cmd[3]), .crcResetCommand(cmd[4]), .releaseSyncCommand(cmd[5]),
		.readbackActive(cmd[6]), .abortActive(cmd[7]), .partialFrameDone(cmd[8]), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.statusOut(statusOut), .donePad_ff(donePad_ff), .initPadN_ff(initPadN_ff),
		.partialDoneEcho(partialDoneEcho), .partialErrorEchoN(partialErrorEchoN));
	cpsm_ctrl_model i_ctrl (.sys_clk(sys_clk), .reset(reset), .statusWord(statusOut), .sawError_ff(sawError_ff));
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task tick;
		@(posedge sys_clk);
		#1;
	endtask
	// Sets the command vector and returns once the design has sampled it.
	task apply(input logic [8:0] v);
		@(posedge sys_clk);
		cmd <= v;
		tick();
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge sys_clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge sys_clk);
		regRead <= 1'b0;
		#1;
		check(regRdData, exp);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (4000) @(posedge sys_clk);
		fails++;
		report_and_stop();
	end
	initial
	begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		tick();
		check(statusOut, 32'h9F);
		check({donePad_ff, initPadN_ff, partialErrorEchoN}, 3'b011);
		apply(9'h001);
		check(donePad_ff, 1'b1);
		apply(9'h002);
		check(statusOut, 32'hDF);
		apply(9'h004);
		check(statusOut, 32'h5F);
		check({initPadN_ff, partialErrorEchoN}, 2'b00);
		tick();
		check(statusOut, 32'h1F);
		apply(9'h002);
		check(statusOut, 32'h5F);
		apply(9'h012);
		check(statusOut, 32'hDF);
		check({initPadN_ff, partialErrorEchoN}, 2'b11);
		apply(9'h032);
		check(statusOut, 32'h9F);
		check(sawError_ff, 1'b1);
		apply(9'h000);
		apply(9'h002);
		apply(9'h00A);
		check(statusOut, 32'h5F);
		check(partialErrorEchoN, 1'b0);
		apply(9'h012);
		check(statusOut, 32'hDF);
		apply(9'h032);
		check(statusOut, 32'h9F);
		$display("test status sequence done");
		apply(9'h040);
		check(statusOut, 32'hBF);
		apply(9'h080);
		check(statusOut, 32'h8F);
		apply(9'h100);
		check(statusOut, 32'h9F);
		check(partialDoneEcho, 1'b1);
		$display("test flag bits done");
		wr(4'h0, 32'h00000001);
		repeat (3) tick();
		check(statusOut, 32'h9B);
		rd(4'h4, 32'h0000009B);
		rd(4'h8, 32'h0000000F);
		rd(4'hC, 32'h00000000);
		$display("test registers done");
		report_and_stop();
	end
endmodule
`default_nettype wire
